// file: gpc_pin_control.v
`timescale 1ns/1ns
`include "gpc_regs.vh"

// Summary of operation
// - Selector bits 11:8, code 0 gives pin data.
// - Codes 1, 2 give high-voltage output data.
// - Codes 3, 4 give converter interrupts.
// - Codes 5, 6 give divided fast, slow oscillators.
// - Codes 7, 8, 9 give mode indications.
// - Code B alarm two, D interrupt OR.
// - Bit 5 selects stronger drive strength.
// - Push-pull: bit 4 sets pin level.
// - Open-drain: one releases, zero pulls low.
// - Bit 3 selects open-drain over push-pull.
// - Bit 2 connects the pull-down resistor.
// - Bit 1 is active-low output enable.
// - Bit 0 enables the input path.
// - Pin two has identical independent register.
module gpc_pin_control #(
    parameter FAST_OSC_HALF = `GPC_FAST_OSC_HALF,
    parameter SLOW_OSC_HALF = `GPC_SLOW_OSC_HALF,
    parameter HOST_IRQ_WIDTH = 8
) (
    input wire clock,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [15:0] reg_rdata,
    input wire high_voltage_out_1,
    input wire high_voltage_out_2,
    input wire converter_interrupt_1,
    input wire converter_interrupt_2,
    input wire active_mode,
    input wire standby_mode,
    input wire low_power_mode,
    input wire switch_driver_state,
    input wire second_alarm,
    input wire [HOST_IRQ_WIDTH-1:0] host_irq_sources,
    input wire pin1_pad_in,
    output reg pin1_pad_out,
    output reg pin1_pad_oe,
    output reg pin1_drive_strength,
    output reg pin1_pulldown_on,
    output reg pin1_in_value,
    input wire pin2_pad_in,
    output reg pin2_pad_out,
    output reg pin2_pad_oe,
    output reg pin2_drive_strength,
    output reg pin2_pulldown_on,
    output reg pin2_in_value
);

    reg [15:0] pin1_control;
    reg [15:0] pin2_control;
    reg [15:0] next_rdata;
    reg [15:0] fast_count;
    reg [15:0] slow_count;
    reg fast_osc_out;
    reg slow_osc_out;
    reg [15:0] sources;
    wire pin1_next_out;
    wire pin1_next_oe;
    wire pin2_next_out;
    wire pin2_next_oe;

    // Drops reserved bits so they neither store nor read back.
    function [15:0] writable;
        input [15:0] value;
        begin
            writable = value & `GPC_CONTROL_WRITE_MASK;
        end
    endfunction

    // Counts a half period and reports the cycle on which it ends.
    function half_done;
        input [15:0] count;
        input integer half;
        begin
            half_done = (count == half[15:0] - 16'h0001);
        end
    endfunction

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pin1_control <= `GPC_CONTROL_RESET;
            pin2_control <= `GPC_CONTROL_RESET;
        end
        else if (reg_write)
        begin
            if (reg_addr == `GPC_PIN1_CONTROL_ADDR)
            begin
                pin1_control <= writable(reg_wdata);
            end
            if (reg_addr == `GPC_PIN2_CONTROL_ADDR)
            begin
                pin2_control <= writable(reg_wdata);
            end
        end
    end

    always @*
    begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `GPC_PIN1_CONTROL_ADDR:
            begin
                next_rdata = writable(pin1_control);
            end
            `GPC_PIN2_CONTROL_ADDR:
            begin
                next_rdata = writable(pin2_control);
            end
            default:
            begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data is registered one cycle after the read strobe.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fast_count <= 16'h0000;
            slow_count <= 16'h0000;
            fast_osc_out <= 1'b0;
            slow_osc_out <= 1'b0;
        end
        else
        begin
            if (half_done(fast_count, FAST_OSC_HALF))
            begin
                fast_count <= 16'h0000;
                fast_osc_out <= ~fast_osc_out;
            end
            else
            begin
                fast_count <= fast_count + 16'h0001;
            end
            if (half_done(slow_count, SLOW_OSC_HALF))
            begin
                slow_count <= 16'h0000;
                slow_osc_out <= ~slow_osc_out;
            end
            else
            begin
                slow_count <= slow_count + 16'h0001;
            end
        end
    end

    always @*
    begin
        sources = 16'h0000;
        sources[`GPC_SRC_HV_OUT_1] = high_voltage_out_1;
        sources[`GPC_SRC_HV_OUT_2] = high_voltage_out_2;
        sources[`GPC_SRC_CONV_IRQ_1] = converter_interrupt_1;
        sources[`GPC_SRC_CONV_IRQ_2] = converter_interrupt_2;
        sources[`GPC_SRC_FAST_OSC] = fast_osc_out;
        sources[`GPC_SRC_SLOW_OSC] = slow_osc_out;
        sources[`GPC_SRC_ACTIVE] = active_mode;
        sources[`GPC_SRC_STANDBY] = standby_mode;
        sources[`GPC_SRC_LOW_POWER] = low_power_mode;
        sources[`GPC_SRC_SWITCH_DRV] = switch_driver_state;
        sources[`GPC_SRC_ALARM_2] = second_alarm;
        sources[`GPC_SRC_HOST_IRQ] = |host_irq_sources;
    end

    gpc_pin_drive pin1_drive (
        .source_select(pin1_control[`GPC_SEL_HI:`GPC_SEL_LO]),
        .out_value(pin1_control[`GPC_OUT_VALUE_BIT]),
        .open_drain_select(pin1_control[`GPC_OPEN_DRAIN_BIT]),
        .output_enable_n(pin1_control[`GPC_OUTPUT_ENABLE_N_BIT]),
        .sources(sources),
        .next_pad_out(pin1_next_out),
        .next_pad_oe(pin1_next_oe)
    );

    gpc_pin_drive pin2_drive (
        .source_select(pin2_control[`GPC_SEL_HI:`GPC_SEL_LO]),
        .out_value(pin2_control[`GPC_OUT_VALUE_BIT]),
        .open_drain_select(pin2_control[`GPC_OPEN_DRAIN_BIT]),
        .output_enable_n(pin2_control[`GPC_OUTPUT_ENABLE_N_BIT]),
        .sources(sources),
        .next_pad_out(pin2_next_out),
        .next_pad_oe(pin2_next_oe)
    );

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pin1_pad_out <= 1'b0;
            pin1_pad_oe <= 1'b0;
            pin1_drive_strength <= 1'b0;
            pin1_pulldown_on <= 1'b0;
            pin1_in_value <= 1'b0;
            pin2_pad_out <= 1'b0;
            pin2_pad_oe <= 1'b0;
            pin2_drive_strength <= 1'b0;
            pin2_pulldown_on <= 1'b0;
            pin2_in_value <= 1'b0;
        end
        else
        begin
            pin1_pad_out <= pin1_next_out;
            pin1_pad_oe <= pin1_next_oe;
            pin2_pad_out <= pin2_next_out;
            pin2_pad_oe <= pin2_next_oe;
            pin1_drive_strength <= pin1_control[`GPC_DRIVE_STRENGTH_BIT];
            pin2_drive_strength <= pin2_control[`GPC_DRIVE_STRENGTH_BIT];
            pin1_pulldown_on <= pin1_control[`GPC_PULLDOWN_BIT];
            pin2_pulldown_on <= pin2_control[`GPC_PULLDOWN_BIT];
            pin1_in_value <= pin1_control[`GPC_INPUT_ENABLE_BIT] & pin1_pad_in;
            pin2_in_value <= pin2_control[`GPC_INPUT_ENABLE_BIT] & pin2_pad_in;
        end
    end

endmodule // gpc_pin_control

// file: gpc_regs.vh
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// Register indices on the register access port.
`define GPC_PIN1_CONTROL_ADDR 8'h0D
`define GPC_PIN2_CONTROL_ADDR 8'h0E

// Field positions inside a pin control register.
`define GPC_SEL_HI 11
`define GPC_SEL_LO 8
`define GPC_DRIVE_STRENGTH_BIT 5
`define GPC_OUT_VALUE_BIT 4
`define GPC_OPEN_DRAIN_BIT 3
`define GPC_PULLDOWN_BIT 2
`define GPC_OUTPUT_ENABLE_N_BIT 1
`define GPC_INPUT_ENABLE_BIT 0

// Reset value and writable bits of a pin control register.
`define GPC_CONTROL_RESET 16'h0002
`define GPC_CONTROL_WRITE_MASK 16'h0F3F

// Output source selector codes.
`define GPC_SRC_GENERAL 4'h0
`define GPC_SRC_HV_OUT_1 4'h1
`define GPC_SRC_HV_OUT_2 4'h2
`define GPC_SRC_CONV_IRQ_1 4'h3
`define GPC_SRC_CONV_IRQ_2 4'h4
`define GPC_SRC_FAST_OSC 4'h5
`define GPC_SRC_SLOW_OSC 4'h6
`define GPC_SRC_ACTIVE 4'h7
`define GPC_SRC_STANDBY 4'h8
`define GPC_SRC_LOW_POWER 4'h9
`define GPC_SRC_SWITCH_DRV 4'hA
`define GPC_SRC_ALARM_2 4'hB
`define GPC_SRC_HOST_IRQ 4'hD

// Half periods of the divided oscillator outputs, in clock cycles.
`define GPC_FAST_OSC_HALF 2
`define GPC_SLOW_OSC_HALF 64

`endif

// file: gpc_pin_drive.v
`timescale 1ns/1ns
`include "gpc_regs.vh"

module gpc_pin_drive (
    input wire [3:0] source_select,
    input wire out_value,
    input wire open_drain_select,
    input wire output_enable_n,
    input wire [15:0] sources,
    output reg next_pad_out,
    output reg next_pad_oe
);

    reg level;

    always @*
    begin
        level = 1'b0;
        case (source_select)
            4'hC, 4'hE, 4'hF:
            begin
                level = 1'b0;
            end
            `GPC_SRC_GENERAL:
            begin
                level = out_value;
            end
            default:
            begin
                level = sources[source_select];
            end
        endcase
        next_pad_out = 1'b0;
        next_pad_oe = 1'b0;
        if (!output_enable_n)
        begin
            if (open_drain_select)
            begin
                next_pad_out = 1'b0;
                next_pad_oe = ~level;
            end
            else
            begin
                next_pad_out = level;
                next_pad_oe = 1'b1;
            end
        end
    end

endmodule // gpc_pin_drive

// file: gpc_board.sv
`timescale 1ns/1ns

module gpc_board (
    input wire pad_out,
    input wire pad_oe,
    input wire pulldown_on,
    output wire pad_in
);
    // released pad level
    // A released pad sits on a weak board pull-up that the internal pull-down overcomes.
    assign pad_in = pad_oe ? pad_out : !pulldown_on;
endmodule // gpc_board

// file: gpc_pin_control_chk.sv
`timescale 1ns/1ns
`include "gpc_regs.vh"

module gpc_pin_control_chk (
    input wire clock,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [15:0] reg_rdata,
    input wire pin1_pad_in,
    input wire pin1_pad_out,
    input wire pin1_pad_oe,
    input wire pin1_drive_strength,
    input wire pin1_pulldown_on,
    input wire pin1_in_value
);
    reg [15:0] sh;
    reg [15:0] p;
    reg pin_d;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sh <= `GPC_CONTROL_RESET;
            p <= `GPC_CONTROL_RESET;
            pin_d <= 1'b0;
        end
        else
        begin
            if (reg_write && reg_addr == 8'h0D)
                sh <= reg_wdata & `GPC_CONTROL_WRITE_MASK;
            p <= sh;
            pin_d <= pin1_pad_in;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_wr;
        reg_write && reg_addr == 8'h0D;
    endsequence
    sequence s_rd;
        reg_read && !reg_write && reg_addr == 8'h0D;
    endsequence
    chk_write_read_back: assert property (s_wr ##1 s_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & 16'h0F3F)) else $error("read back wrong");
    chk_reserved_read_zero: assert property (reg_read |=>
        (reg_rdata & 16'hF0C0) == 16'h0000) else $error("reserved bits set");
    chk_drive_strength_copy: assert property (pin1_drive_strength == p[5])
        else $error("drive strength wrong");
    chk_pulldown_copy: assert property (pin1_pulldown_on == p[2])
        else $error("pull-down wrong");
    chk_input_gate: assert property (pin1_in_value == (p[0] && pin_d))
        else $error("input value wrong");
    chk_output_disabled: assert property (p[1] |-> !pin1_pad_oe && !pin1_pad_out)
        else $error("disabled pin driven");
    chk_open_drain_low: assert property (p[3] |-> !pin1_pad_out)
        else $error("open drain drove high");
    chk_general_data: assert property (p[11:8] == 4'h0 && p[3:1] == 3'h0 |->
        pin1_pad_oe && pin1_pad_out == p[4]) else $error("general data wrong");
endmodule // gpc_pin_control_chk

bind gpc_pin_control gpc_pin_control_chk u_chk (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pin1_pad_in(pin1_pad_in), .pin1_pad_out(pin1_pad_out),
    .pin1_pad_oe(pin1_pad_oe), .pin1_drive_strength(pin1_drive_strength),
    .pin1_pulldown_on(pin1_pulldown_on), .pin1_in_value(pin1_in_value));

// file: gpc_pin_control_tb.sv
`timescale 1ns/1ns
`include "gpc_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module gpc_pin_control_tb;
    reg clock = 0;
    reg resetn = 0;
    reg [7:0] reg_addr = 0;
    reg [15:0] reg_wdata = 0;
    reg reg_write = 0;
    reg reg_read = 0;
    reg [8:0] src = 0;
    reg [7:0] irq = 0;
    reg look = 0;
    reg b;
    wire [15:0] reg_rdata;
    wire o1, e1, s1, d1, v1, i1, o2, e2, s2, d2, v2, i2;
    integer fail_count = 0, checks_done = 0, seed = 3445, c, n, k;
    reg [16:0] q [$];
    reg [16:0] e;
    reg [15:0] r, r2;
    initial forever #25 clock = ~clock;
    gpc_pin_control u_dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .high_voltage_out_1(src[0]), .high_voltage_out_2(src[1]),
        .converter_interrupt_1(src[2]), .converter_interrupt_2(src[3]), .active_mode(src[4]),
        .standby_mode(src[5]), .low_power_mode(src[6]), .switch_driver_state(src[7]),
        .second_alarm(src[8]), .host_irq_sources(irq), .pin1_pad_in(i1), .pin1_pad_out(o1),
        .pin1_pad_oe(e1), .pin1_drive_strength(s1), .pin1_pulldown_on(d1), .pin1_in_value(v1),
        .pin2_pad_in(i2), .pin2_pad_out(o2), .pin2_pad_oe(e2), .pin2_drive_strength(s2),
        .pin2_pulldown_on(d2), .pin2_in_value(v2));
    gpc_board u_board1 (.pad_out(o1), .pad_oe(e1), .pulldown_on(d1), .pad_in(i1));
    gpc_board u_board2 (.pad_out(o2), .pad_oe(e2), .pulldown_on(d2), .pad_in(i2));
    function [1:0] drv(input [15:0] x, input l);
        drv = x[1] ? 2'b00 : x[3] ? {!l, 1'b0} : {1'b1, l};
    endfunction
    function lvl(input [15:0] x);
        k = x[11:8];
        lvl = k == 0 ? x[4] : k < 5 ? src[k-1] : (k > 6 && k < 12) ? src[k-3] : k == 13 && |irq;
    endfunction
    function [4:0] pin_exp(input [15:0] x, input l);
        pin_exp[1:0] = drv(x, l);
        pin_exp[4] = x[0] & (pin_exp[1:0] == 2'b11 || (pin_exp[1:0] == 2'b00 && !x[2]));
        pin_exp[3:2] = {x[2], x[5]};
    endfunction
    // Maps forbidden codes, and the oscillator codes where asked, to code zero.
    function [3:0] code(input integer v, input osc);
        code = (v == 12 || v > 13 || (!osc && (v == 5 || v == 6))) ? 4'h0 : v[3:0];
    endfunction
    task note(input [16:0] v);
        @(posedge clock);
        q.push_back(v);
        look <= 1;
        @(posedge clock);
        look <= 0;
    endtask
    task wr(input [7:0] a, input [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1;
        @(posedge clock);
        reg_write <= 0;
    endtask
    task wr_rd(input [7:0] a, input [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1;
        @(posedge clock);
        reg_write <= 0;
        reg_read <= 1;
        @(posedge clock);
        reg_read <= 0;
        note({1'b0, v & `GPC_CONTROL_WRITE_MASK});
    endtask
    task rd(input [7:0] a, input [15:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clock);
        reg_read <= 0;
        note({1'b0, v});
    endtask
    task report_and_stop;
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock)
        if (look)
        begin
            e = q.pop_front();
            if (e[16]) `CHK({6'h00, v2, d2, s2, e2, o2, v1, d1, s1, e1, o1}, e[15:0])
            else `CHK(reg_rdata, e[15:0])
        end
    initial
    begin
        #500000;
        fail_count++;
        report_and_stop;
    end
    initial
    begin
        repeat (12) @(posedge clock);
        resetn <= 1;
        rd(8'h0D, 16'h0002);
        rd(8'h0E, 16'h0002);
        rd(8'h10, 16'h0000);
        for (n = 0; n < 48; n++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            r[11:8] = code(n % 16, 1'b1);
            r[1] = n > 31;
            r2[11:8] = code((n + 7) % 16, 1'b0);
            @(posedge clock);
            src <= $random(seed);
            irq <= (n % 3 == 0) ? 8'h00 : $random(seed);
            wr(8'h0E, r2);
            wr_rd(8'h0D, r);
            if (r[11:8] != 5 && r[11:8] != 6)
                note({1'b1, 6'h00, pin_exp(r2, lvl(r2)), pin_exp(r, lvl(r))});
        end
        for (c = 5; c < 7; c++)
        begin
            wr(8'h0D, {4'h0, c[3:0], 8'h00});
            repeat (2) @(posedge clock);
            n = 0;
            repeat (256)
            begin
                b = o1;
                @(posedge clock);
                #1 n += (o1 != b);
            end
            `CHK(n, c == 5 ? 128 : 4)
        end
        report_and_stop;
    end
endmodule // gpc_pin_control_tb
